// File: rtl/rsc_pkg.sv
// Shared constants, register map and carrier types of the reset controller
`default_nettype none
package rsc_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int NREG          = 41;
  localparam int CNT_W         = 18;
  // Stabilization wait in main-clock periods, two to the 17th
  localparam int STAB_EXP      = 17;
  localparam int STAB_CYCLES_D = 1 << STAB_EXP;
  // Least low time of the reset pin, in ns, and its clock count
  localparam int EXT_LOW_NS    = 10_000;
  localparam int CLK_NS        = 10;
  localparam int EXT_LOW_CYC   = (EXT_LOW_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Addresses on the register port and the vector fetch port
  // ****************************************************************
  localparam logic [15:0] REG_BASE      = 16'hFF00;
  localparam logic [15:0] ADDR_MEM_CAP  = 16'hFFF0;
  localparam logic [15:0] ADDR_STAB_SEL = 16'hFFFA;
  localparam logic [15:0] ADDR_CTRL     = 16'hFF80;
  localparam logic [15:0] ADDR_STATUS   = 16'hFF81;
  localparam logic [15:0] ADDR_PC_LO    = 16'hFF82;
  localparam logic [15:0] ADDR_PC_HI    = 16'hFF83;
  localparam logic [15:0] VEC_ADDR_LO   = 16'h0000;
  localparam logic [15:0] VEC_ADDR_HI   = 16'h0001;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RV_CLEAR    = 8'h00;
  localparam logic [7:0] RV_SET      = 8'hFF;
  localparam logic [7:0] RV_PSW      = 8'h02;
  localparam logic [7:0] RV_CPU_CLK  = 8'h04;
  localparam logic [7:0] RV_STAB_SEL = 8'h04;
  localparam logic [7:0] RV_MEM_CAP  = 8'hCF;
  localparam logic [7:0] RV_CTRL     = 8'h01;
  localparam int CTRL_WDT_EN = 0;
  localparam int ST_EXT      = 0;
  localparam int ST_WDT      = 1;
  localparam int ST_STBY     = 2;
  localparam int ST_RUN      = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    R_PSW, R_SP, R_PORT_LATCH, R_PORT_DIR, R_PULLUP, R_CPU_CLK,
    R_MEM_CAP, R_MEM_EXP, R_STAB_SEL, R_WT_CNT_LO, R_WT_CNT_HI,
    R_WT_CC, R_WT_PRESC, R_WT_MODE, R_WT_CAPCTL, R_WT_OUTCTL,
    R_NT_CNT0, R_NT_CNT1, R_NT_CMP, R_NT_CLKSEL, R_NT_MODE,
    R_WATCH_MODE, R_WD_CLKSEL, R_WD_MODE, R_CLK_BUZ, R_CONV_RES,
    R_CONV_MODE, R_ANALOG_SEL, R_ASYNC_MODE, R_ASYNC_STAT,
    R_BAUD, R_ASYNC_TX, R_ASYNC_RX, R_CSER_MODE0, R_CSER_MODE1,
    R_CSER_SHIFT, R_INT_REQ, R_INT_MASK, R_INT_PRIO, R_EDGE_RISE,
    R_EDGE_FALL
  } rsc_reg_e;

  typedef enum logic [2:0] {
    PH_HOLD, PH_STAB, PH_FETCH_LO, PH_FETCH_HI, PH_LOAD, PH_RUN
  } rsc_phase_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } rsc_bus_req_t;

  typedef struct packed {
    logic ext_reset_n;
    logic wdt_overflow;
    logic in_standby;
  } rsc_src_t;

  typedef struct packed {
    logic sys_reset;
    logic pins_hiz;
    logic main_osc_stop;
    logic stop_hold;
    logic cpu_run;
  } rsc_ctl_t;

  // Bit 8 says whether a system reset loads bits 7:0
  function automatic logic [8:0] reg_init(input int idx);
    case (idx)
      int'(R_PSW):        reg_init = {1'b1, RV_PSW};
      int'(R_PORT_DIR),
      int'(R_ASYNC_TX),
      int'(R_ASYNC_RX),
      int'(R_INT_MASK),
      int'(R_INT_PRIO):   reg_init = {1'b1, RV_SET};
      int'(R_CPU_CLK):    reg_init = {1'b1, RV_CPU_CLK};
      int'(R_STAB_SEL):   reg_init = {1'b1, RV_STAB_SEL};
      int'(R_MEM_CAP):    reg_init = {1'b1, RV_MEM_CAP};
      int'(R_SP),
      int'(R_WT_CC),
      int'(R_NT_CMP),
      int'(R_CSER_SHIFT): reg_init = {1'b0, RV_CLEAR};
      default:            reg_init = {1'b1, RV_CLEAR};
    endcase
  endfunction

  function automatic logic [15:0] reg_addr(input int idx);
    if (idx == int'(R_MEM_CAP)) begin
      reg_addr = ADDR_MEM_CAP;
    end else if (idx == int'(R_STAB_SEL)) begin
      reg_addr = ADDR_STAB_SEL;
    end else begin
      reg_addr = REG_BASE + 16'(idx);
    end
  endfunction

endpackage
`default_nettype wire

// File: rtl/rsc_byte_reg.sv
// One byte register that a system reset loads with its reset value
`default_nettype none
module rsc_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter bit         HAS_RESET = 1'b1
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);
  logic [7:0] q;
  logic [7:0] next_q;

  // ****************************************************************
  // Next value
  // ****************************************************************
  // Registers without a reset value keep their contents across reset
  always_comb begin
    next_q = q;
    if (sys_rst_i) begin
      if (HAS_RESET) begin
        next_q = RESET_VAL;
      end
    end else if (wr_i) begin
      next_q = wdata_i;
    end
  end

  // Power-on clear gives even undefined registers a known value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= HAS_RESET ? RESET_VAL : 8'h00;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign q_o = q;
endmodule // rsc_byte_reg
`default_nettype wire

// File: rtl/rsc_reset_ctrl.sv
// System reset controller: sources, stabilization wait, vector fetch
// Sequence: HOLD while any source requests, then the stabilization wait,
// two vector reads, one load cycle and RUN. Registers with a reset value are
// forced to it in every phase but RUN, so software can
// never catch a half-initialised block.
`default_nettype none
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int STAB_CYCLES = rsc_pkg::STAB_CYCLES_D
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire rsc_pkg::rsc_src_t     src_i,
  input  wire rsc_pkg::rsc_bus_req_t bus_i,
  output logic               [7:0]   bus_rdata_o,
  output logic                       vec_rd_o,
  output logic               [15:0]  vec_addr_o,
  input  wire logic          [7:0]   vec_data_i,
  output rsc_pkg::rsc_ctl_t          ctl_o,
  output logic                       ram_retain_o,
  output logic               [15:0]  program_counter_o,
  output logic [rsc_pkg::NREG-1:0][7:0] reg_bank_o
);
  import rsc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  // Phase walks HOLD, STAB, FETCH_LO, FETCH_HI, LOAD and RUN in order;
  // any request drops it back to HOLD from wherever it stands. The
  // counter only moves in STAB and is cleared on every entry.
  typedef struct packed {
    logic             pin_meta;
    logic             pin_sync;
    rsc_phase_e       phase;
    logic [CNT_W-1:0] count;
    logic [7:0]       vec_lo;
    logic [15:0]      pc;
    logic             cause_ext;
    logic             cause_wdt;
    logic             standby_kept;
    logic             run_seen;
    logic             wdt_en;
    logic [7:0]       rdata;
  } rsc_state_t;

  rsc_state_t st;
  rsc_state_t next_st;

  // Decoded requests, read mux and bank write selects
  logic             ext_req;
  logic             wdt_req;
  logic             any_req;
  logic             sys_rst;
  logic             hit_any;
  logic [7:0]       rd_val;
  logic [7:0]       status_val;
  logic [NREG-1:0]  wr_sel;
  logic [CNT_W-1:0] stab_last;

  // Last count of the wait; parameter narrowed to the counter width
  // The counter is wide enough for the full default wait and one more
  assign stab_last = CNT_W'(STAB_CYCLES - 1);

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // Pin low time is not measured: a glitch that survives both stages
  // still resets, which errs on the safe side
  // Pin is asynchronous, so only the second stage is ever looked at
  assign ext_req = ~st.pin_sync;
  // Watchdog overflow comes from the same clock and needs no stage
  assign wdt_req = src_i.wdt_overflow & st.wdt_en;
  // Both sources feed one request, so their effect on the sequence is identical
  assign any_req = ext_req | wdt_req;

  // Registers with a reset value stay at it until the CPU runs
  assign sys_rst = (st.phase != PH_RUN);

  // ****************************************************************
  // Status register view
  // ****************************************************************
  // Cause flags, standby mark and run bit; the flags are sticky so that
  // software can learn why it restarted long after the event
  always_comb begin
    status_val          = 8'h00;
    status_val[ST_EXT]  = st.cause_ext;
    status_val[ST_WDT]  = st.cause_wdt;
    status_val[ST_STBY] = st.standby_kept;
    status_val[ST_RUN]  = (st.phase == PH_RUN);
  end

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  // Bank lookup first, then the controller's own addresses; the two sets
  // never overlap, so the order only keeps the mux shallow
  // Unmapped addresses read as zero
  always_comb begin
    rd_val  = 8'h00;
    hit_any = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      if (bus_i.addr == reg_addr(i)) begin
        rd_val  = reg_bank_o[i];
        hit_any = 1'b1;
      end
    end
    if (!hit_any) begin
      case (bus_i.addr)
        // Watchdog enable; a system reset keeps it, power-on or a written one sets it
        ADDR_CTRL: begin
          rd_val = {7'b0, st.wdt_en};
        end
        ADDR_STATUS: begin
          rd_val = status_val;
        end
        // Counter is cleared at power-on; reads give zero until it is loaded
        ADDR_PC_LO: begin
          rd_val = st.pc[7:0];
        end
        ADDR_PC_HI: begin
          rd_val = st.pc[15:8];
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // One pass computes the whole next state. Bus writes come first, so a
  // reset request in the same cycle overrides them: a cause flag cleared
  // by software and set by hardware at once stays set, and no phase
  // change is ever lost to a register access.
  always_comb begin
    next_st          = st;
    next_st.pin_meta = src_i.ext_reset_n;
    next_st.pin_sync = st.pin_meta;

    // Read data stands only in the cycle after the strobe
    if (bus_i.rd) begin
      next_st.rdata = rd_val;
    end else begin
      next_st.rdata = 8'h00;
    end

    // Control register: watchdog reset enable
    if (bus_i.wr && bus_i.addr == ADDR_CTRL) begin
      next_st.wdt_en = bus_i.wdata[CTRL_WDT_EN];
    end

    // Cause flags clear on a written one; a new cause below wins
    if (bus_i.wr && bus_i.addr == ADDR_STATUS) begin
      if (bus_i.wdata[ST_EXT]) begin
        next_st.cause_ext = 1'b0;
      end
      if (bus_i.wdata[ST_WDT]) begin
        next_st.cause_wdt = 1'b0;
      end
      if (bus_i.wdata[ST_STBY]) begin
        next_st.standby_kept = 1'b0;
      end
    end

    if (any_req) begin
      // Any source restarts the whole sequence from zero
      next_st.phase = PH_HOLD;
      next_st.count = '0;
      if (ext_req) begin
        next_st.cause_ext = 1'b1;
      end
      if (wdt_req) begin
        next_st.cause_wdt = 1'b1;
      end
      // A reset taken in standby keeps memory and STOP contents
      // Judged only from RUN, so a request during the wait keeps the mark
      if (src_i.in_standby && st.phase == PH_RUN) begin
        next_st.standby_kept = 1'b1;
      end
    end else begin
      case (st.phase)
        // Pin high again or watchdog pulse over: start the wait
        PH_HOLD: begin
          next_st.phase = PH_STAB;
          next_st.count = '0;
        end
        // Wait of two to the 17th clocks, set by the STAB_CYCLES default
        // Count runs 0 to the last value, so STAB lasts STAB_CYCLES
        PH_STAB: begin
          if (st.count == stab_last) begin
            next_st.phase = PH_FETCH_LO;
            next_st.count = '0;
          end else begin
            next_st.count = st.count + CNT_W'(1);
          end
        end
        // Low vector byte returns in the cycle after its strobe
        PH_FETCH_LO: begin
          next_st.phase = PH_FETCH_HI;
        end
        PH_FETCH_HI: begin
          next_st.vec_lo = vec_data_i;
          next_st.phase  = PH_LOAD;
        end
        PH_LOAD: begin
          next_st.pc    = {vec_data_i, st.vec_lo};
          next_st.phase = PH_RUN;
        end
        // Execution goes on until the next reset request
        PH_RUN: begin
          next_st.phase = PH_RUN;
        end
        // Unused phase codes fall back to a clean hold
        default: begin
          next_st.phase = PH_HOLD;
          next_st.count = '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on starts in reset hold with the pin assumed low
  // Enable low freezes everything, the synchroniser too, so a pin pulse
  // that ends while frozen is never seen
  // Status and control survive a system reset; only power-on reloads them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.pin_meta     <= 1'b0;
      st.pin_sync     <= 1'b0;
      st.phase        <= PH_HOLD;
      st.count        <= '0;
      st.vec_lo       <= 8'h00;
      st.pc           <= 16'h0000;
      st.cause_ext    <= 1'b0;
      st.cause_wdt    <= 1'b0;
      st.standby_kept <= 1'b0;
      st.run_seen     <= 1'b0;
      st.wdt_en       <= RV_CTRL[CTRL_WDT_EN];
      st.rdata        <= 8'h00;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Reset-valued register bank
  // ****************************************************************
  // Writes are ignored while the system is held in reset
  // Undefined registers skip the system reset load but are still cleared
  // at power-on, so simulation never starts from unknowns
  for (genvar g = 0; g < NREG; g++) begin : g_bank
    localparam logic [8:0] INIT = reg_init(g);
    // Value and defined flag come from the table
    assign wr_sel[g] = bus_i.wr && (bus_i.addr == reg_addr(g));
    rsc_byte_reg #(
      .RESET_VAL (INIT[7:0]),
      .HAS_RESET (INIT[8])
    ) u_reg (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .sys_rst_i (sys_rst),
      .wr_i      (wr_sel[g]),
      .wdata_i   (bus_i.wdata),
      .q_o       (reg_bank_o[g])
    );
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Fetch phases stop floating the pins, but the system reset stays up
  // until the counter is loaded, so no peripheral sees a half start
  // Ports float through hold and wait, STOP or not
  always_comb begin
    ctl_o               = '0;
    ctl_o.sys_reset     = sys_rst;
    ctl_o.pins_hiz      = (st.phase == PH_HOLD) ||
                          (st.phase == PH_STAB);
    // Only the main oscillator stops; subsystem clock is untouched
    ctl_o.main_osc_stop = (st.phase == PH_HOLD);
    ctl_o.stop_hold     = (st.phase == PH_HOLD) &&
                          st.standby_kept;
    ctl_o.cpu_run       = (st.phase == PH_RUN);
  end

  // Vector strobes: one read per byte, low byte first
  // Memory answers a cycle late: FETCH_HI takes low, LOAD the high byte
  assign vec_rd_o   = (st.phase == PH_FETCH_LO) ||
                      (st.phase == PH_FETCH_HI);
  assign vec_addr_o = (st.phase == PH_FETCH_HI) ? VEC_ADDR_HI
                                                : VEC_ADDR_LO;

  // Memory is never cleared here; the flag tells its keeper why
  // Sticky until software writes a one to the standby bit
  assign ram_retain_o      = st.standby_kept;
  assign program_counter_o = st.pc;
  assign bus_rdata_o       = st.rdata;

endmodule // rsc_reset_ctrl
`default_nettype wire

// File: bench/rsc_vec_mem.sv
// Vector memory model facing the reset controller fetch port
`default_nettype none
module rsc_vec_mem (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] vec_i,
  output logic      [7:0]  data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Memory
  // ********
  initial data_o = 8'h5a;
  // Data stands one cycle after the strobe; each idle cycle shows the inverse
  // of the cycle before, so a capture one cycle late cannot match by luck
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= (addr_i == 16'h0000) ? vec_i[7:0] : vec_i[15:8];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule // rsc_vec_mem
`default_nettype wire

// File: bench/rsc_reset_ctrl_assertions.sv
// Port checker for the reset controller and its bind
`default_nettype none
module rsc_chk
  import rsc_pkg::*;
#(
  parameter int STAB_CYCLES = 16
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ce_i,
  input wire rsc_pkg::rsc_src_t     src_i,
  input wire rsc_pkg::rsc_bus_req_t bus_i,
  input wire logic [7:0]            bus_rdata_o,
  input wire logic                  vec_rd_o,
  input wire logic [15:0]           vec_addr_o,
  input wire logic [7:0]            vec_data_i,
  input wire rsc_pkg::rsc_ctl_t     ctl_o,
  input wire logic                  ram_retain_o,
  input wire logic [15:0]           program_counter_o,
  input wire logic [rsc_pkg::NREG-1:0][7:0] reg_bank_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Helpers
  // ********
  int         cnt;
  logic       wen;
  logic       lo_d;
  logic       hi_d;
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  // Wait length, watchdog enable shadow and fetched vector bytes
  always_ff @(posedge clk_i) begin
    lo_d <= ce_i && vec_rd_o && vec_addr_o == VEC_ADDR_LO;
    hi_d <= ce_i && vec_rd_o && vec_addr_o == VEC_ADDR_HI;
    if (lo_d) lo_q <= vec_data_i;
    if (hi_d) hi_q <= vec_data_i;
    if (rst_i || ctl_o.main_osc_stop) cnt <= 0;
    else if (ce_i && ctl_o.pins_hiz) cnt <= cnt + 1;
    if (rst_i) wen <= 1'b1;
    else if (ce_i && bus_i.wr && bus_i.addr == ADDR_CTRL)
      wen <= bus_i.wdata[CTRL_WDT_EN];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ********
  // Assertions
  // ********
  AST_PIN_ENTER: assert property (
    (!src_i.ext_reset_n && ce_i) [*3] |=> ctl_o.main_osc_stop)
    else $error("pin low did not enter reset hold");
  AST_WDT_ENTER: assert property (
    ce_i && src_i.wdt_overflow && wen |=> ctl_o.main_osc_stop)
    else $error("watchdog overflow did not enter reset hold");
  AST_HOLD_HIZ: assert property (
    ctl_o.main_osc_stop |-> ctl_o.pins_hiz && ctl_o.sys_reset
      && !ctl_o.cpu_run)
    else $error("hold phase lost floating pins or reset");
  AST_STAB_LEN: assert property (
    $fell(ctl_o.pins_hiz) |-> cnt == STAB_CYCLES)
    else $error("stabilization wait length wrong");
  AST_FETCH: assert property (
    $fell(ctl_o.pins_hiz) |-> vec_rd_o && vec_addr_o == VEC_ADDR_LO
      ##1 vec_rd_o && vec_addr_o == VEC_ADDR_HI)
    else $error("vector fetch order wrong");
  AST_PC_LOAD: assert property (
    $rose(ctl_o.cpu_run) |-> program_counter_o == {hi_q, lo_q})
    else $error("program counter not loaded from vector");
  AST_RUN: assert property (
    ctl_o.cpu_run |-> !ctl_o.sys_reset && !ctl_o.pins_hiz && !vec_rd_o)
    else $error("running while reset outputs active");
  AST_RDATA_IDLE: assert property (
    !(ce_i && bus_i.rd) |=> bus_rdata_o == 8'h00)
    else $error("read data not zero without a read");
  AST_STAB_VALUES: assert property (
    ctl_o.pins_hiz && !ctl_o.main_osc_stop |-> reg_bank_o[R_PSW] == 8'h02
      && reg_bank_o[R_STAB_SEL] == 8'h04 && reg_bank_o[R_MEM_CAP] == 8'hCF)
    else $error("reset values missing during wait");
  AST_STOP_HOLD: assert property (
    ctl_o.stop_hold |-> ctl_o.pins_hiz ##[0:2] ram_retain_o)
    else $error("standby reset did not keep memory");
  // Main scenarios
  cover property ($rose(ctl_o.cpu_run));
  cover property (ctl_o.stop_hold);
  cover property (src_i.wdt_overflow && ctl_o.cpu_run);
endmodule // rsc_chk
bind rsc_reset_ctrl rsc_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .src_i(src_i),
  .bus_i(bus_i), .bus_rdata_o(bus_rdata_o), .vec_rd_o(vec_rd_o),
  .vec_addr_o(vec_addr_o), .vec_data_i(vec_data_i), .ctl_o(ctl_o),
  .ram_retain_o(ram_retain_o), .program_counter_o(program_counter_o),
  .reg_bank_o(reg_bank_o));
`default_nettype wire

// File: bench/rsc_reset_ctrl_tb.sv
// Self-checking bench for the reset controller
`default_nettype none
module rsc_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  logic                 clk_i;
  logic                 rst_i;
  logic                 ce_i;
  logic                 vrd;
  logic                 retain;
  rsc_src_t             src;
  rsc_bus_req_t         bus;
  rsc_ctl_t             ctl;
  logic [7:0]           rdata;
  logic [7:0]           vdata;
  logic [15:0]          vaddr;
  logic [15:0]          pc;
  logic [15:0]          vec;
  logic [NREG-1:0][7:0] bank;
  int                   fail_count;
  int                   checked;
  int                   model [NREG];
  // ********
  // Structure
  // ********
  // Short wait keeps the run brief
  rsc_reset_ctrl #(.STAB_CYCLES(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .src_i(src), .bus_i(bus),
    .bus_rdata_o(rdata), .vec_rd_o(vrd), .vec_addr_o(vaddr),
    .vec_data_i(vdata), .ctl_o(ctl), .ram_retain_o(retain),
    .program_counter_o(pc), .reg_bank_o(bank));
  rsc_vec_mem u_mem (
    .clk_i(clk_i), .rd_i(vrd), .addr_i(vaddr), .vec_i(vec), .data_o(vdata));
  // Clock at 100 MHz
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    // Taken at the edge that closes the cycle in which the data stand
    @(posedge clk_i);
    d = rdata;
  endtask
  // Reset value per register; -1 marks the ones left undefined
  function automatic int rv(input int i);
    case (i)
      R_PSW: rv = 8'h02;
      R_PORT_DIR, R_ASYNC_TX, R_ASYNC_RX, R_INT_MASK, R_INT_PRIO: rv = 8'hFF;
      R_CPU_CLK, R_STAB_SEL: rv = 8'h04;
      R_MEM_CAP: rv = 8'hCF;
      R_SP, R_WT_CC, R_NT_CMP, R_CSER_SHIFT: rv = -1;
      default: rv = 8'h00;
    endcase
  endfunction
  function automatic logic [15:0] ad(input int i);
    if (i == R_MEM_CAP) ad = 16'hFFF0;
    else if (i == R_STAB_SEL) ad = 16'hFFFA;
    else ad = 16'hFF00 + 16'(i);
  endfunction
  // Undefined registers keep their value unless power-on reset clears them
  task automatic model_reset(input bit por);
    for (int i = 0; i < NREG; i++) begin
      if (rv(i) >= 0) model[i] = rv(i);
      else if (por) model[i] = 0;
    end
  endtask
  task automatic check_bank();
    for (int i = 0; i < NREG; i++) chk(bank[i], model[i][7:0]);
  endtask
  // Bounded wait for execution to start, then the vector
  task automatic wait_run();
    int n;
    n = 0;
    while (ctl.cpu_run !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 400) begin
        fail_count++;
        conclude();
      end
    end
    chk(pc, vec);
  endtask
  task automatic pin_reset(input bit stby);
    src <= '{ext_reset_n: 1'b0, wdt_overflow: 1'b0, in_standby: stby};
    wr(ad(R_PSW), 8'h55);
    repeat (1000) @(posedge clk_i);
    chk({ctl.sys_reset, ctl.pins_hiz, ctl.main_osc_stop}, 3'b111);
    chk(ctl.stop_hold, stby);
    chk(bank[R_PSW], 8'h02);
    src <= '{ext_reset_n: 1'b1, wdt_overflow: 1'b0, in_standby: 1'b0};
  endtask
  task automatic wdt_pulse();
    @(posedge clk_i);
    src.wdt_overflow <= 1'b1;
    @(posedge clk_i);
    src.wdt_overflow <= 1'b0;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    logic [7:0] d;
    fail_count = 0;
    checked = 0;
    d = 8'($urandom(32'h771f));
    rst_i = 1'b1;
    ce_i = 1'b1;
    src = '{ext_reset_n: 1'b1, wdt_overflow: 1'b0, in_standby: 1'b0};
    bus = '0;
    vec = 16'($urandom);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    model_reset(1'b1);
    wait_run();
    check_bank();
    rd(16'hFFFA, d);
    chk(d, 8'h04);
    rd(16'hFE00, d);
    chk(d, 8'h00);
    rd(16'hFF82, d);
    chk(d, vec[7:0]);
    // Random contents, then a read while the clock enable is low
    for (int i = 0; i < NREG; i++) begin
      d = 8'($urandom);
      wr(ad(i), d);
      model[i] = d;
    end
    // The last write landed at the edge that ended wr; look one edge later
    @(posedge clk_i);
    check_bank();
    ce_i <= 1'b0;
    rd(ad(R_PSW), d);
    chk(d, 8'h00);
    ce_i <= 1'b1;
    // Watchdog reset, hit again in mid-wait
    wr(16'hFF81, 8'h07);
    vec <= 16'($urandom);
    wdt_pulse();
    repeat (10) @(posedge clk_i);
    wdt_pulse();
    model_reset(1'b0);
    wait_run();
    check_bank();
    rd(16'hFF81, d);
    chk(d[3:0], 4'b1010);
    // Pin reset from run, then from standby
    wr(16'hFF81, 8'h07);
    vec <= 16'($urandom);
    pin_reset(1'b0);
    wait_run();
    check_bank();
    chk(retain, 1'b0);
    rd(16'hFF81, d);
    chk(d[3:0], 4'b1001);
    wr(16'hFF81, 8'h07);
    pin_reset(1'b1);
    wait_run();
    chk(retain, 1'b1);
    rd(16'hFF81, d);
    chk(d[3:0], 4'b1101);
    // Watchdog reset disabled by software
    wr(16'hFF80, 8'h00);
    wdt_pulse();
    repeat (4) @(posedge clk_i);
    #1 chk(ctl.cpu_run, 1'b1);
    conclude();
  end
endmodule // rsc_reset_ctrl_tb
`default_nettype wire
